/* File: logic/map_select_pkg.sv */
// Operation
// - address-select pin drives main address bit 1
// - address bit 0 picks read or write
// - reset routes main map to user sub map
// - select field 01 routes to interrupt map
// - select field 10 routes to second user map
// - post-processor address from 0xfd bits 7:1
// - post-processor address resets 0x00, no answer
// - video transmitter address from 0xfe bits 7:1
// - video transmitter address resets 0x00, no answer
// - auxiliary maps ignore pin and select field
package map_select_pkg;

  // ----------------------------------------------------------------
  // slave addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_ADDR_BASE    = 8'h40;
  localparam logic [7:0] ADDR_SEL_MASK     = 8'h02;
  localparam int         DIR_BIT           = 0;
  localparam logic [6:0] AUX_ADDR_UNSET    = 7'h00;

  // ----------------------------------------------------------------
  // register offsets, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SUBMAP_CTRL   = 8'h0e;
  localparam logic [7:0] OFS_POSTPROC_ADDR = 8'hfd;
  localparam logic [7:0] OFS_VIDEOTX_ADDR  = 8'hfe;
  localparam int         SUBMAP_LSB        = 5;
  localparam int         SUBMAP_MSB        = 6;
  localparam logic [1:0] SUBMAP_USER       = 2'h0;
  localparam logic [1:0] SUBMAP_INTR       = 2'h1;
  localparam logic [1:0] SUBMAP_USER2      = 2'h2;
  localparam logic [7:0] RST_SUBMAP_CTRL   = 8'h00;
  localparam logic [7:0] RST_POSTPROC_ADDR = 8'h00;
  localparam logic [7:0] RST_VIDEOTX_ADDR  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MAP_NONE, MAP_USER, MAP_INTR, MAP_USER2, MAP_POSTPROC, MAP_VIDEOTX} map_t;
  typedef enum logic {ST_IDLE, ST_SELECTED} sess_t;

endpackage

/* File: logic/slave_addr_match.sv */
`timescale 1ns/1ps
module slave_addr_match
  import map_select_pkg::*;
(
  input  logic [7:0] target,
  input  logic       enable,
  input  logic [7:0] addr_byte,
  output logic       hit
);

  // the direction bit never takes part, so read address is write address plus one
  assign hit = enable & (addr_byte[7:1] == target[7:1]);

endmodule // slave_addr_match

/* File: logic/register_map_address_select.sv */
`timescale 1ns/1ps
module register_map_address_select
  import map_select_pkg::*;
(
  input  logic       sys_clk,
  input  logic       rst,
  input  logic       address_select_pin,
  input  logic       addr_valid,
  input  logic [7:0] addr_byte,
  input  logic       stop_seen,
  input  logic       reg_wr,
  input  logic       reg_rd,
  input  logic [7:0] reg_sub,
  input  logic [7:0] reg_wdata,
  output logic       addr_ack,
  output map_t       map_sel,
  output logic       read_mode,
  output logic       own_reg_hit,
  output logic [7:0] reg_rdata,
  output logic       reg_rdata_valid,
  output logic [1:0] submap_select_field,
  output logic [7:0] postproc_slave_addr,
  output logic [7:0] video_tx_slave_addr,
  output logic [7:0] main_write_addr
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic       pin_meta_q;
  logic       pin_sync_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] pp_addr_q;
  logic [7:0] pp_addr_d;
  logic [7:0] vt_addr_q;
  logic [7:0] vt_addr_d;
  sess_t      sess_q;
  sess_t      sess_d;
  map_t       map_q;
  map_t       map_d;
  logic       dir_q;
  logic       dir_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic [7:0] main_addr_q;
  logic [7:0] main_addr_d;

  wire  [1:0] field_now;
  wire        main_hit;
  wire        pp_hit;
  wire        vt_hit;
  wire        pp_enable;
  wire        vt_enable;
  wire        any_hit;
  map_t       main_target;
  map_t       addr_target;
  wire        selected;
  wire        wr_ok;
  wire        rd_ok;
  wire        hit_ctrl;
  wire        hit_pp;
  wire        hit_vt;
  wire        hit_any;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // 0x0e is reachable from every main sub map so the master can always
  // leave a sub map; the slave address registers live in the user sub map only
  function automatic logic own_hit(input logic [7:0] sub, input map_t m, input logic [7:0] ofs);
    logic main_map;
    main_map = (m == MAP_USER) | (m == MAP_INTR) | (m == MAP_USER2);
    own_hit  = main_map & (sub == ofs) & ((ofs == OFS_SUBMAP_CTRL) | (m == MAP_USER));
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= address_select_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // slave address decode
  // ----------------------------------------------------------------
  assign main_addr_d = pin_sync_q ? (MAIN_ADDR_BASE | ADDR_SEL_MASK)
                                  : (MAIN_ADDR_BASE & ~ADDR_SEL_MASK);
  // an address of zero in bits 7:1 leaves the map deaf
  assign pp_enable = (pp_addr_q[7:1] != AUX_ADDR_UNSET);
  assign vt_enable = (vt_addr_q[7:1] != AUX_ADDR_UNSET);

  slave_addr_match u_main_match (
    .target    (main_addr_q),
    .enable    (1'b1),
    .addr_byte (addr_byte),
    .hit       (main_hit)
  );

  // auxiliary maps compare only against their own register
  slave_addr_match u_pp_match (
    .target    (pp_addr_q),
    .enable    (pp_enable),
    .addr_byte (addr_byte),
    .hit       (pp_hit)
  );

  slave_addr_match u_vt_match (
    .target    (vt_addr_q),
    .enable    (vt_enable),
    .addr_byte (addr_byte),
    .hit       (vt_hit)
  );

  assign field_now = ctrl_q[SUBMAP_MSB:SUBMAP_LSB];
  assign any_hit   = main_hit | pp_hit | vt_hit;

  // reserved code 11 falls back to the user sub map so the bus never locks out
  always_comb begin
    case (field_now)
      SUBMAP_USER:  main_target = MAP_USER;
      SUBMAP_INTR:  main_target = MAP_INTR;
      SUBMAP_USER2: main_target = MAP_USER2;
      default:      main_target = MAP_USER;
    endcase
  end

  // main map wins if software programs an auxiliary map onto its address
  always_comb begin
    if (main_hit) begin
      addr_target = main_target;
    end else if (pp_hit) begin
      addr_target = MAP_POSTPROC;
    end else if (vt_hit) begin
      addr_target = MAP_VIDEOTX;
    end else begin
      addr_target = MAP_NONE;
    end
  end

  assign addr_ack = addr_valid & any_hit;

  // ----------------------------------------------------------------
  // transaction state
  // ----------------------------------------------------------------
  // a repeated start re-decodes; the target is fixed for the rest of the
  // transaction even if 0x0e is rewritten inside it
  always_comb begin
    sess_d = sess_q;
    map_d  = map_q;
    dir_d  = dir_q;
    if (addr_valid) begin
      dir_d = addr_byte[DIR_BIT];
      if (any_hit) begin
        sess_d = ST_SELECTED;
        map_d  = addr_target;
      end else begin
        sess_d = ST_IDLE;
        map_d  = MAP_NONE;
      end
    end else if (stop_seen) begin
      sess_d = ST_IDLE;
      map_d  = MAP_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sess_q <= ST_IDLE;
      map_q  <= MAP_NONE;
      dir_q  <= 1'b0;
    end else begin
      sess_q <= sess_d;
      map_q  <= map_d;
      dir_q  <= dir_d;
    end
  end

  // ----------------------------------------------------------------
  // own register access
  // ----------------------------------------------------------------
  assign selected = (sess_q == ST_SELECTED);
  assign wr_ok    = selected & reg_wr & ~dir_q;
  assign rd_ok    = selected & reg_rd & dir_q;
  assign hit_ctrl = own_hit(reg_sub, map_q, OFS_SUBMAP_CTRL);
  assign hit_pp   = own_hit(reg_sub, map_q, OFS_POSTPROC_ADDR);
  assign hit_vt   = own_hit(reg_sub, map_q, OFS_VIDEOTX_ADDR);
  assign hit_any  = hit_ctrl | hit_pp | hit_vt;

  // nothing but a write or reset changes the field, so the choice outlives stops
  assign ctrl_d    = (wr_ok & hit_ctrl) ? reg_wdata : ctrl_q;
  assign pp_addr_d = (wr_ok & hit_pp)   ? reg_wdata : pp_addr_q;
  assign vt_addr_d = (wr_ok & hit_vt)   ? reg_wdata : vt_addr_q;

  assign rdata_d  = ~rd_ok    ? rdata_q   :
                    hit_ctrl  ? ctrl_q    :
                    hit_pp    ? pp_addr_q :
                    hit_vt    ? vt_addr_q : UNMAPPED_READ;
  assign rvalid_d = rd_ok & hit_any;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q      <= RST_SUBMAP_CTRL;
      pp_addr_q   <= RST_POSTPROC_ADDR;
      vt_addr_q   <= RST_VIDEOTX_ADDR;
      rdata_q     <= UNMAPPED_READ;
      rvalid_q    <= 1'b0;
      main_addr_q <= MAIN_ADDR_BASE;
    end else begin
      ctrl_q      <= ctrl_d;
      pp_addr_q   <= pp_addr_d;
      vt_addr_q   <= vt_addr_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
      main_addr_q <= main_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign map_sel             = map_q;
  assign read_mode           = dir_q;
  assign own_reg_hit         = selected & hit_any;
  assign reg_rdata           = rdata_q;
  assign reg_rdata_valid     = rvalid_q;
  assign submap_select_field = field_now;
  assign postproc_slave_addr = pp_addr_q;
  assign video_tx_slave_addr = vt_addr_q;
  assign main_write_addr     = main_addr_q;

endmodule // register_map_address_select

/* File: sim/map_select_properties.sv */
`timescale 1ns/1ps
module map_select_properties
  import map_select_pkg::*;
(
  input logic       sys_clk,
  input logic       rst,
  input logic       address_select_pin,
  input logic       addr_valid,
  input logic [7:0] addr_byte,
  input logic       stop_seen,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_sub,
  input logic [7:0] reg_wdata,
  input logic       addr_ack,
  input map_t       map_sel,
  input logic       read_mode,
  input logic       own_reg_hit,
  input logic [7:0] reg_rdata,
  input logic       reg_rdata_valid,
  input logic [1:0] submap_select_field,
  input logic [7:0] postproc_slave_addr,
  input logic [7:0] video_tx_slave_addr,
  input logic [7:0] main_write_addr
);
  // ----------------------------------------------------------------
  // decode relations
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire main_hit = addr_valid && addr_byte[7:1] == main_write_addr[7:1];
  wire [6:0] pp = postproc_slave_addr[7:1];
  wire [6:0] vt = video_tx_slave_addr[7:1];
  // 0x0e answers in all three main sub maps, the two address registers only in the user sub map
  wire own_main = map_sel == MAP_USER || map_sel == MAP_INTR || map_sel == MAP_USER2;
  wire own_exp  = own_main && reg_sub == 8'h0e || map_sel == MAP_USER && (reg_sub == 8'hfd || reg_sub == 8'hfe);
  a_own_hit: assert property (own_reg_hit == own_exp) else $error("own register hit wrong");
  a_main_ack: assert property (main_hit |-> addr_ack) else $error("main address not acknowledged");
  a_pin_bit: assert property ($stable(address_select_pin) [*4] |->
    main_write_addr == {6'h10, address_select_pin, 1'b0}) else $error("main address wrong");
  a_dir_latch: assert property (addr_valid |=> read_mode == $past(addr_byte[0]))
    else $error("direction not latched");
  a_user_route: assert property (main_hit && submap_select_field[0] == submap_select_field[1] |=>
    map_sel == MAP_USER) else $error("user map not chosen");
  a_intr_route: assert property (main_hit && submap_select_field == 2'h1 |=> map_sel == MAP_INTR)
    else $error("interrupt map not chosen");
  a_user2_route: assert property (main_hit && submap_select_field == 2'h2 |=> map_sel == MAP_USER2)
    else $error("second user map not chosen");
  a_pp_route: assert property (addr_valid && !main_hit && pp != 7'h0 && addr_byte[7:1] == pp |->
    addr_ack ##1 map_sel == MAP_POSTPROC) else $error("post map not chosen");
  a_vt_route: assert property (addr_valid && !main_hit && vt != 7'h0 && vt != pp && addr_byte[7:1] == vt |->
    addr_ack ##1 map_sel == MAP_VIDEOTX) else $error("tx map not chosen");
  a_aux_unset: assert property (addr_valid && !main_hit && pp == 7'h0 && vt == 7'h0 |->
    !addr_ack ##1 map_sel == MAP_NONE) else $error("unset map answered");
  a_field_hold: assert property ($changed(submap_select_field) |-> $past(reg_wr) && $past(reg_sub) == 8'h0e)
    else $error("select field moved");
  c_intr: cover property (main_hit && submap_select_field == 2'h1);
  c_aux: cover property (addr_valid && !main_hit && addr_ack);
  c_read: cover property (reg_rdata_valid);
endmodule // map_select_properties

/* File: sim/serial_master_model.sv */
`timescale 1ns/1ps
module serial_master_model (
  input  logic       sys_clk,
  input  logic       addr_ack,
  input  logic [7:0] reg_rdata,
  input  logic       reg_rdata_valid,
  output logic       addr_valid,
  output logic [7:0] addr_byte,
  output logic       stop_seen,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_sub,
  output logic [7:0] reg_wdata
);
  initial begin
    {addr_valid, stop_seen, reg_wr, reg_rd} = '0;
    {addr_byte, reg_sub, reg_wdata} = '0;
  end
  // released lines carry the inverse of the last value, so a stale copy is never taken
  task automatic address(input logic [7:0] a, output logic ack);
    @(posedge sys_clk) #1 addr_valid = 1'b1;
    addr_byte = a;
    @(posedge sys_clk) ack = addr_ack;
    #1 addr_valid = 1'b0;
    addr_byte = ~a;
  endtask
  task automatic write_reg(input logic [7:0] s, input logic [7:0] d);
    @(posedge sys_clk) #1 reg_wr = 1'b1;
    reg_sub = s;
    reg_wdata = d;
    @(posedge sys_clk) #1 reg_wr = 1'b0;
    reg_sub = ~s;
    reg_wdata = ~d;
  endtask
  task automatic read_reg(input logic [7:0] s, output logic [7:0] d, output logic v);
    @(posedge sys_clk) #1 reg_rd = 1'b1;
    reg_sub = s;
    @(posedge sys_clk) #1 reg_rd = 1'b0;
    reg_sub = ~s;
    d = reg_rdata;
    v = reg_rdata_valid;
  endtask
  task automatic stop();
    @(posedge sys_clk) #1 stop_seen = 1'b1;
    @(posedge sys_clk) #1 stop_seen = 1'b0;
  endtask
endmodule // serial_master_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
bind register_map_address_select map_select_properties map_select_properties_i (.*);
module tb
  import map_select_pkg::*;
;
  logic       sys_clk = 0, rst = 1, address_select_pin = 0;
  logic       addr_valid, stop_seen, reg_wr, reg_rd, addr_ack, read_mode, own_reg_hit, reg_rdata_valid;
  logic [7:0] addr_byte, reg_sub, reg_wdata, reg_rdata, postproc_slave_addr, video_tx_slave_addr, main_write_addr;
  logic [1:0] submap_select_field;
  map_t       map_sel;
  map_t       tbl [4] = '{MAP_USER, MAP_INTR, MAP_USER2, MAP_USER};
  int         n_fail = 0, checks = 0;
  register_map_address_select register_map_address_select_i (.*);
  serial_master_model serial_master_model_i (.*);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic open_map(input logic [7:0] a, input logic ack_x, input map_t map_x);
    logic ack;
    serial_master_model_i.address(a, ack);
    #5;
    `CHK(ack, ack_x)
    `CHK(map_sel, map_x)
    `CHK(read_mode, a[0])
  endtask
  task automatic rreg(input logic [7:0] s, input logic [7:0] x);
    logic [7:0] d;
    logic       v;
    serial_master_model_i.read_reg(s, d, v);
    `CHK(v, 1'b1)
    `CHK(d, x)
  endtask
  initial begin
    #50000;
    n_fail++;
    wrap_up;
  end
  initial begin
    logic [1:0] f;
    logic [7:0] d;
    logic       v;
    repeat (6) @(posedge sys_clk);
    #1 rst = 0;
    open_map(8'h41, 1'b1, MAP_USER);
    rreg(8'h0e, 8'h00);
    rreg(8'hfd, 8'h00);
    rreg(8'hfe, 8'h00);
    open_map(8'h00, 1'b0, MAP_NONE);
    open_map(8'h42, 1'b0, MAP_NONE);
    for (int i = 1; i < 5; i++) begin
      f = i[1:0];
      open_map(8'h40, 1'b1, tbl[f - 2'h1]);
      serial_master_model_i.write_reg(8'h0e, {1'b0, f, 5'h00});
      serial_master_model_i.stop();
      open_map(8'h41, 1'b1, tbl[f]);
      rreg(8'h0e, {1'b0, f, 5'h00});
      `CHK(submap_select_field, f)
    end
    open_map(8'h40, 1'b1, MAP_USER);
    serial_master_model_i.write_reg(8'hfd, 8'h84);
    serial_master_model_i.write_reg(8'hfe, 8'h88);
    serial_master_model_i.write_reg(8'h0e, 8'h20);
    serial_master_model_i.stop();
    address_select_pin = 1;
    repeat (5) @(posedge sys_clk);
    #1 `CHK(main_write_addr, 8'h42)
    `CHK(postproc_slave_addr, 8'h84)
    `CHK(video_tx_slave_addr, 8'h88)
    `CHK(submap_select_field, 2'h1)
    open_map(8'h85, 1'b1, MAP_POSTPROC);
    serial_master_model_i.read_reg(8'hfd, d, v);
    `CHK(v, 1'b0)
    open_map(8'h88, 1'b1, MAP_VIDEOTX);
    open_map(8'h40, 1'b0, MAP_NONE);
    open_map(8'h42, 1'b1, MAP_INTR);
    serial_master_model_i.write_reg(8'h0e, 8'h00);
    open_map(8'h43, 1'b1, MAP_USER);
    rreg(8'hfe, 8'h88);
    // a second reset in mid-run must forget the field and both auxiliary addresses
    rst = 1;
    repeat (2) @(posedge sys_clk);
    #1 rst = 0;
    `CHK(submap_select_field, 2'h0)
    `CHK(postproc_slave_addr, 8'h00)
    `CHK(video_tx_slave_addr, 8'h00)
    `CHK(main_write_addr, 8'h40)
    open_map(8'h85, 1'b0, MAP_NONE);
    open_map(8'h89, 1'b0, MAP_NONE);
    open_map(8'h43, 1'b1, MAP_USER);
    wrap_up;
  end
endmodule // tb
